// [hw/fer_consts.vh]
`ifndef FER_CONSTS_VH
`define FER_CONSTS_VH

// ----------------------------------------
// Register offsets (word index = byte/4)
// ----------------------------------------
`define FER_OFS_CTRL        8'h00
`define FER_OFS_IRQ_STAT    8'h04
`define FER_OFS_IRQ_MASK    8'h08
`define FER_OFS_PWR_CYC     8'h0c
`define FER_OFS_CNT_SHUT    8'h10
`define FER_OFS_CNT_WARN    8'h14
`define FER_OFS_REC_SEL     8'h18
`define FER_OFS_REC_DATA    8'h1c
`define FER_OFS_NV_SHUT     8'h20
`define FER_OFS_NV_WARN     8'h24

// ----------------------------------------
// Record layout
// ----------------------------------------
`define FER_REC_BYTES       38
`define FER_REC_DEPTH       5
`define FER_REC_W           304

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define FER_CTRL_LOAD_BIT   0
`define FER_IRQ_EVT_BIT     0
`define FER_IRQ_NVS_BIT     1
`define FER_IRQ_NVW_BIT     2
`define FER_CNT_MAX         4'hf
`define FER_PCYC_MAX        16'hffff
`define FER_MASK_RST        3'h0

`endif

// [hw/fer_recorder.v]
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "fer_consts.vh"

// How it works
// - Count request-off cycles while AC present
// - Snapshot status and telemetry on event
// - Keep totals, copy into record
// - Event counters saturate at fifteen
// - Shutdown counters packed low/high nibbles
// - Warning counters packed low/high nibbles
// - Save shutdown counts on each event except one in the cycle of a load
// - Increment when status bit asserts
// - Warning counts kept in working memory
// - Warnings count only rising edge
// - Persisting warning never recounted
// - Save warnings to storage at shutdown
// - Keep four older 38-byte records
// - Newest record holds latest event
// - Count AC loss while request asserted
module fer_recorder (
	// Clock and reset
	input  wire         CLK_SYS_I,
	input  wire         RSTN_I,
	// Register port
	input  wire [7:0]   ADDR_I,
	input  wire [31:0]  WDATA_I,
	input  wire         WR_I,
	input  wire         RD_I,
	output reg  [31:0]  RDATA_O,
	output reg          IRQ_O,
	// Supply pins and events
	input  wire         POWER_ON_REQUEST_N_I,
	input  wire         AC_OK_I,
	input  wire         BB_EVENT_I,
	input  wire         PSU_SHUTDOWN_I,
	input  wire [5:0]   SHUT_BITS_I,
	input  wire [3:0]   WARN_BITS_I,
	// Telemetry snapshot sources
	input  wire [15:0]  STATUS_WORD_I,
	input  wire [7:0]   STATUS_IOUT_I,
	input  wire [7:0]   STATUS_INPUT_I,
	input  wire [7:0]   TEMPERATURE_STATUS_BYTE_I,
	input  wire [7:0]   STATUS_FAN_I,
	input  wire [127:0] READINGS_I,
	input  wire [23:0]  TOTAL_ON_I,
	input  wire [31:0]  RTC_I,
	// Non-volatile storage
	output reg          NV_SHUT_WR_O,
	output reg  [23:0]  NV_SHUT_DATA_O,
	output reg          NV_WARN_WR_O,
	output reg  [15:0]  NV_WARN_DATA_O
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	reg [13:0] sy1_q;
	reg [13:0] sy2_q;
	wire [13:0] raw = {BB_EVENT_I, PSU_SHUTDOWN_I, AC_OK_I, POWER_ON_REQUEST_N_I,
		SHUT_BITS_I, WARN_BITS_I};

	always @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			sy1_q <= 14'h0000;
			sy2_q <= 14'h0000;
		end else begin
			sy1_q <= raw;
			sy2_q <= sy1_q;
		end
	end

	wire       evt_s   = sy2_q[13];
	wire       shd_s   = sy2_q[12];
	wire       ac_s    = sy2_q[11];
	wire       req_n_s = sy2_q[10];
	wire [5:0] shb_s   = sy2_q[9:4];
	wire [3:0] wnb_s   = sy2_q[3:0];

	reg  [13:0] prev_q;
	reg  [1:0]  warm_q;
	wire        live;

	// Edges count only once the pipeline holds real pin levels,
	// else a pin idling high fakes an edge after reset
	always @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I)
			prev_q <= 14'h0000;
		else
			prev_q <= sy2_q;
	end

	always @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I)
			warm_q <= 2'h0;
		else if (warm_q != 2'h3)
			warm_q <= warm_q + 2'h1;
	end

	assign live = (warm_q == 2'h3);

	wire       evt_p   = live & evt_s & ~prev_q[13];
	wire       shd_p   = live & shd_s & ~prev_q[12];
	wire       ac_up   = live & ac_s & ~prev_q[11];
	wire       ac_dn   = live & ~ac_s & prev_q[11];
	wire       req_off = live & req_n_s & ~prev_q[10];
	wire [5:0] sh_p    = {6{live}} & shb_s & ~prev_q[9:4];
	wire [3:0] wn_p    = {4{live}} & wnb_s & ~prev_q[3:0];

	// ----------------------------------------
	// Saturating increment
	// ----------------------------------------
	function [3:0] sat_inc;
		input [3:0] v;
		input       en;
		begin
			if (en && v != `FER_CNT_MAX)
				sat_inc = v + 4'h1;
			else
				sat_inc = v;
		end
	endfunction

	// ----------------------------------------
	// Register write decode
	// ----------------------------------------
	function wr_hit;
		input       wr;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			wr_hit = wr && (addr == ofs);
		end
	endfunction

	// ----------------------------------------
	// Power-cycle counters
	// ----------------------------------------
	reg [15:0] req_cyc_q;
	reg [15:0] ac_cyc_q;
	reg        ac_armed_q;

	// Request-driven cycles count only while AC is present
	always @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I)
			req_cyc_q <= 16'h0000;
		else if (req_off && ac_s && req_cyc_q != `FER_PCYC_MAX)
			req_cyc_q <= req_cyc_q + 16'h0001;
	end

	// AC loss armed only if the request stood at the loss
	always @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			ac_cyc_q   <= 16'h0000;
			ac_armed_q <= 1'b0;
		end else begin
			if (ac_dn)
				ac_armed_q <= ~req_n_s;
			if (ac_up && ac_armed_q) begin
				ac_armed_q <= 1'b0;
				if (ac_cyc_q != `FER_PCYC_MAX)
					ac_cyc_q <= ac_cyc_q + 16'h0001;
			end
		end
	end

	// ----------------------------------------
	// Event counters
	// ----------------------------------------
	reg [23:0] shut_q;
	reg [15:0] warn_q;
	wire       load_w = wr_hit(WR_I, ADDR_I, `FER_OFS_CTRL) && WDATA_I[`FER_CTRL_LOAD_BIT];
	wire       nvs_w  = wr_hit(WR_I, ADDR_I, `FER_OFS_NV_SHUT);
	wire       nvw_w  = wr_hit(WR_I, ADDR_I, `FER_OFS_NV_WARN);
	reg [23:0] nv_shut_img_q;
	reg [15:0] nv_warn_img_q;

	wire [23:0] shut_d;
	wire [15:0] warn_d;
	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_shut
			assign shut_d[g*4 +: 4] = sat_inc(shut_q[g*4 +: 4], sh_p[g]);
		end
		for (g = 0; g < 4; g = g + 1) begin : g_warn
			assign warn_d[g*4 +: 4] = sat_inc(warn_q[g*4 +: 4], wn_p[g]);
		end
	endgenerate

	always @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			shut_q        <= 24'h000000;
			warn_q        <= 16'h0000;
			nv_shut_img_q <= 24'h000000;
			nv_warn_img_q <= 16'h0000;
		end else begin
			if (nvs_w)
				nv_shut_img_q <= WDATA_I[23:0];
			if (nvw_w)
				nv_warn_img_q <= WDATA_I[15:0];
			// Load beats a same-cycle increment
			if (load_w) begin
				shut_q <= nv_shut_img_q;
				warn_q <= nv_warn_img_q;
			end else begin
				shut_q <= shut_d;
				warn_q <= warn_d;
			end
		end
	end

	// ----------------------------------------
	// Non-volatile write-out
	// ----------------------------------------
	always @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			NV_SHUT_WR_O   <= 1'b0;
			NV_SHUT_DATA_O <= 24'h000000;
		end else begin
			NV_SHUT_WR_O   <= |sh_p && !load_w;
			NV_SHUT_DATA_O <= shut_d;
		end
	end

	// Warning totals leave working memory only at shutdown
	always @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			NV_WARN_WR_O   <= 1'b0;
			NV_WARN_DATA_O <= 16'h0000;
		end else begin
			NV_WARN_WR_O   <= shd_p && !load_w;
			NV_WARN_DATA_O <= warn_d;
		end
	end

	// ----------------------------------------
	// Record history
	// ----------------------------------------
	reg [`FER_REC_W-1:0] rec_q [0:`FER_REC_DEPTH-1];
	wire [`FER_REC_W-1:0] snap = {
		RTC_I,
		TOTAL_ON_I,
		ac_cyc_q,
		req_cyc_q,
		STATUS_WORD_I,
		STATUS_IOUT_I,
		STATUS_INPUT_I,
		TEMPERATURE_STATUS_BYTE_I,
		STATUS_FAN_I,
		READINGS_I,
		shut_d,
		warn_d
	};
	integer i;

	// Newest slot takes the capture, the oldest falls off

	always @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			for (i = 0; i < `FER_REC_DEPTH; i = i + 1)
				rec_q[i] <= {`FER_REC_W{1'b0}};
		end else if (evt_p) begin
			rec_q[0] <= snap;
			for (i = 1; i < `FER_REC_DEPTH; i = i + 1)
				rec_q[i] <= rec_q[i-1];
		end
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	reg  [2:0] irq_stat_q;
	reg  [2:0] irq_mask_q;
	wire       wr_stat_w = wr_hit(WR_I, ADDR_I, `FER_OFS_IRQ_STAT);
	wire       wr_mask_w = wr_hit(WR_I, ADDR_I, `FER_OFS_IRQ_MASK);
	wire [2:0] irq_set   = {NV_WARN_WR_O, NV_SHUT_WR_O, evt_p};
	wire [2:0] irq_clr   = wr_stat_w ? WDATA_I[2:0] : 3'h0;
	// A new event beats a clear in the same cycle
	wire [2:0] irq_next  = (irq_stat_q & ~irq_clr) | irq_set;

	always @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I)
			irq_stat_q <= 3'h0;
		else
			irq_stat_q <= irq_next;
	end

	always @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I)
			irq_mask_q <= `FER_MASK_RST;
		else if (wr_mask_w)
			irq_mask_q <= WDATA_I[2:0];
	end

	// Output follows the next status so it drops with the clear
	always @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I)
			IRQ_O <= 1'b0;
		else
			IRQ_O <= |(irq_next & irq_mask_q);
	end

	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	reg  [6:0]  sel_q;
	reg  [31:0] rd_d;
	wire [2:0]  sel_rec  = (sel_q[6:4] < 3'h5) ? sel_q[6:4] : 3'h0;
	wire [3:0]  sel_word = sel_q[3:0];
	// Word nine holds the top half-word, low aligned
	wire [8:0]  sel_bit  = (sel_word < 4'h9) ? {sel_word, 5'h00} : 9'h000;

	always @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I)
			sel_q <= 7'h00;
		else if (wr_hit(WR_I, ADDR_I, `FER_OFS_REC_SEL))
			sel_q <= WDATA_I[6:0];
	end

	always @* begin
		rd_d = 32'h00000000;
		case (ADDR_I)
			`FER_OFS_IRQ_STAT: rd_d = {29'h0, irq_stat_q};
			`FER_OFS_IRQ_MASK: rd_d = {29'h0, irq_mask_q};
			`FER_OFS_PWR_CYC:  rd_d = {ac_cyc_q, req_cyc_q};
			`FER_OFS_CNT_SHUT: rd_d = {8'h00, shut_q};
			`FER_OFS_CNT_WARN: rd_d = {16'h0000, warn_q};
			`FER_OFS_REC_SEL:  rd_d = {25'h0, sel_q};
			`FER_OFS_REC_DATA: begin
				if (sel_word < 4'h9)
					rd_d = rec_q[sel_rec][sel_bit +: 32];
				else if (sel_word == 4'h9)
					rd_d = {16'h0000, rec_q[sel_rec][`FER_REC_W-1 -: 16]};
			end
			`FER_OFS_NV_SHUT:  rd_d = {8'h00, nv_shut_img_q};
			`FER_OFS_NV_WARN:  rd_d = {16'h0000, nv_warn_img_q};
			default:           rd_d = 32'h00000000;
		endcase
	end

	always @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I)
			RDATA_O <= 32'h00000000;
		else
			RDATA_O <= RD_I ? rd_d : 32'h00000000;
	end

endmodule

// [test/fer_nv_model.sv]
`timescale 1ns/1ps
module fer_nv_model (
	// Clock
	input  wire        clk_i,
	// Writes from the recorder
	input  wire        shut_wr_i,
	input  wire [23:0] shut_data_i,
	input  wire        warn_wr_i,
	input  wire [15:0] warn_data_i,
	// Stored images
	output reg  [23:0] shut_img_o,
	output reg  [15:0] warn_img_o
);
	always @(posedge clk_i) begin
		if (shut_wr_i) shut_img_o <= shut_data_i;
		if (warn_wr_i) warn_img_o <= warn_data_i;
	end
endmodule

// [test/fer_chk.sv]
`timescale 1ns/1ps
module fer_chk (
	// Clock, reset, bus
	input wire        CLK_SYS_I,
	input wire        RSTN_I,
	input wire        WR_I,
	input wire        RD_I,
	input wire [31:0] RDATA_O,
	input wire        IRQ_O,
	// Events and storage
	input wire        PSU_SHUTDOWN_I,
	input wire [5:0]  SHUT_BITS_I,
	input wire        NV_SHUT_WR_O,
	input wire        NV_WARN_WR_O
);
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (!RSTN_I);
	chk_rd_idle: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
		else $error("read data outside read slot");
	chk_shut_save: assert property (
		(SHUT_BITS_I & ~$past(SHUT_BITS_I)) != 6'h0 |-> ##[3:5] NV_SHUT_WR_O)
		else $error("no shutdown save after event");
	chk_shut_quiet: assert property ($stable(SHUT_BITS_I) [*7] |-> !NV_SHUT_WR_O)
		else $error("shutdown save without event");
	chk_shut_pulse: assert property (NV_SHUT_WR_O |=> !NV_SHUT_WR_O)
		else $error("shutdown save longer than one cycle");
	chk_warn_save: assert property ($rose(PSU_SHUTDOWN_I) |-> ##[3:5] NV_WARN_WR_O)
		else $error("no warning save at shutdown");
	chk_warn_quiet: assert property ($stable(PSU_SHUTDOWN_I) [*7] |-> !NV_WARN_WR_O)
		else $error("warning save without shutdown");
	chk_warn_pulse: assert property (NV_WARN_WR_O |=> !NV_WARN_WR_O)
		else $error("warning save longer than one cycle");
	chk_irq_drop: assert property ($fell(IRQ_O) |-> $past(WR_I) || $past(WR_I, 2))
		else $error("interrupt dropped without a write");
endmodule
bind fer_recorder fer_chk fer_chk_i (.*);

// [test/tb_top.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
	$display("unexpected at %0t: %h exp %h", $time, a, b); end end
module tb_top;
	reg         clk_sys, rstn, wr, rd, req_n, ac_ok, bb_evt, psu_shut;
	reg  [7:0]  addr, snap;
	reg  [31:0] wdata, rv;
	reg  [5:0]  shut_bits;
	reg  [3:0]  warn_bits;
	reg  [3:0]  sc [0:5];
	reg  [3:0]  wc [0:3];
	reg  [7:0]  hist [0:5];
	wire [31:0] rdata;
	wire        irq, nvs_wr, nvw_wr;
	wire [23:0] nvs_data, nvs_img;
	wire [15:0] nvw_data, nvw_img;
	int         errors, samples_checked, cyc, i, k;
	localparam [23:0] PIN_SEQ = 24'b110100011110111000101101;
	fer_recorder fer_recorder_i (.CLK_SYS_I(clk_sys), .RSTN_I(rstn), .ADDR_I(addr),
		.WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq),
		.POWER_ON_REQUEST_N_I(req_n), .AC_OK_I(ac_ok), .BB_EVENT_I(bb_evt),
		.PSU_SHUTDOWN_I(psu_shut), .SHUT_BITS_I(shut_bits), .WARN_BITS_I(warn_bits),
		.STATUS_WORD_I({2{snap}}), .STATUS_IOUT_I(snap), .STATUS_INPUT_I(snap),
		.TEMPERATURE_STATUS_BYTE_I(snap), .STATUS_FAN_I(snap), .READINGS_I({16{snap}}),
		.TOTAL_ON_I({3{snap}}), .RTC_I({4{snap}}),
		.NV_SHUT_WR_O(nvs_wr), .NV_SHUT_DATA_O(nvs_data), .NV_WARN_WR_O(nvw_wr),
		.NV_WARN_DATA_O(nvw_data));
	fer_nv_model fer_nv_model_i (.clk_i(clk_sys), .shut_wr_i(nvs_wr), .shut_data_i(nvs_data),
		.warn_wr_i(nvw_wr), .warn_data_i(nvw_data), .shut_img_o(nvs_img), .warn_img_o(nvw_img));
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 2000) begin
			errors++;
			report_and_stop();
		end
	end
	function automatic [3:0] sat(input [3:0] v);
		sat = (v == 4'hf) ? v : v + 4'h1;
	endfunction
	function automatic [23:0] shut_pack();
		for (int j = 0; j < 6; j++) shut_pack[4*j +: 4] = sc[j];
	endfunction
	function automatic [15:0] warn_pack();
		for (int j = 0; j < 4; j++) warn_pack[4*j +: 4] = wc[j];
	endfunction
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic wr_reg(input [7:0] a, input [31:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input [7:0] a, input [31:0] e);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 `CHK(rdata, e)
	endtask
	task automatic pins(input r, input a);
		req_n <= r;
		ac_ok <= a;
		idle(5);
	endtask
	task automatic report_and_stop();
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		{rstn, wr, rd, req_n, bb_evt, psu_shut, addr, wdata, snap} = '0;
		{shut_bits, warn_bits} = '0;
		ac_ok = 1'b1;
		rv = $urandom(32'ha6b5);
		repeat (4) @(posedge clk_sys);
		rstn <= 1'b1;
		rv = $urandom;
		wr_reg(8'h20, rv[23:0]);
		wr_reg(8'h24, rv[31:16]);
		wr_reg(8'h00, 32'h1);
		for (k = 0; k < 6; k++) sc[k] = rv[4*k +: 4];
		for (k = 0; k < 4; k++) wc[k] = rv[16+4*k +: 4];
		rd_chk(8'h10, shut_pack());
		rd_chk(8'h14, warn_pack());
		for (k = 11; k >= 0; k--) pins(PIN_SEQ[2*k+1], PIN_SEQ[2*k]);
		rd_chk(8'h0c, 32'h0001_0002);
		for (i = 0; i < 80; i++) begin
			rv = $urandom;
			if (i % 20 == 19) rv[9:0] = 10'h3ff;
			for (k = 0; k < 6; k++) if (rv[k] && !shut_bits[k]) sc[k] = sat(sc[k]);
			for (k = 0; k < 4; k++) if (rv[6+k] && !warn_bits[k]) wc[k] = sat(wc[k]);
			shut_bits <= rv[5:0];
			warn_bits <= rv[9:6];
			idle(5);
		end
		rd_chk(8'h10, shut_pack());
		rd_chk(8'h14, warn_pack());
		`CHK(nvs_img, shut_pack())
		psu_shut <= 1'b1;
		idle(4);
		psu_shut <= 1'b0;
		idle(2);
		`CHK(nvw_img, warn_pack())
		for (i = 0; i < 6; i++) begin
			hist[i] = $urandom;
			snap <= hist[i];
			bb_evt <= 1'b1;
			idle(5);
			bb_evt <= 1'b0;
			idle(2);
		end
		for (i = 0; i < 5; i++) begin
			wr_reg(8'h18, {25'h0, i[2:0], 4'h3});
			rd_chk(8'h1c, {4{hist[5-i]}});
		end
		rv = shut_pack();
		wr_reg(8'h18, 32'h0);
		rd_chk(8'h1c, {rv[15:0], warn_pack()});
		wr_reg(8'h18, 32'h6);
		rd_chk(8'h1c, {8'h02, {3{hist[5]}}});
		wr_reg(8'h18, 32'h7);
		rd_chk(8'h1c, {hist[5], 16'h0001, 8'h00});
		wr_reg(8'h18, 32'h9);
		rd_chk(8'h1c, {16'h0000, {2{hist[5]}}});
		wr_reg(8'h04, 32'h7);
		bb_evt <= 1'b1;
		idle(5);
		rd_chk(8'h04, 32'h1);
		`CHK(irq, 1'b0)
		wr_reg(8'h08, 32'h1);
		idle(2);
		`CHK(irq, 1'b1)
		wr_reg(8'h04, 32'h1);
		idle(3);
		`CHK(irq, 1'b0)
		rd_chk(8'h40, 32'h0);
		report_and_stop();
	end
endmodule
